/* File: verilog/sled_cfg.svh */
// Constants for the serial line error detector: codes and buffer geometry
`ifndef SLED_CFG_SVH
`define SLED_CFG_SVH
// ============================================================
// Error codes
`define SLED_CODE_OVERRUN   16'h7F67
`define SLED_CODE_FRAMING   16'h7F68
`define SLED_CODE_PARITY    16'h7F69
`define SLED_CODE_BUF_FULL  16'h7F6A
`define SLED_CODE_CARRIER   16'h7F6B
`define SLED_CODE_TX_REFUSE 16'h7F6C
`define SLED_CODE_NONE      16'h0000
// ============================================================
// Buffer geometry
`define SLED_FIFO_DEPTH     8
`define SLED_DATA_W         8
`endif

/* File: verilog/sled_pkg.sv */
// Types shared by the serial line error detector files
package sled_pkg;
    // Received character with its line checks
    typedef struct packed {
        logic [7:0] data;      // Character bits
        logic       stop_ok;   // Stop bit matched the setting
        logic       parity_ok; // Parity matched the setting
    } sled_rx_char_type;

    // Indicator flags
    typedef struct packed {
        logic serial_err;  // Framing, overrun, buffer full
        logic parity_err;  // Parity only
        logic channel_err; // Carrier or transmit refusal
    } sled_flags_type;
endpackage

/* File: verilog/sled_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sled_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    // Fill side
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    input  wire logic [WIDTH-1:0] wr_data_in,
    // Drain side
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in,
    output logic [WIDTH-1:0]      rd_data_out,
    // Drop everything
    input  wire logic             flush_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];  // Storage
    logic [AW-1:0]    wp_r;           // Write pointer
    logic [AW-1:0]    rp_r;           // Read pointer
    logic [AW:0]      cnt_r;          // Fill level
    logic             push;
    logic             pop;

    assign wr_ready_out = (cnt_r != DEPTH[AW:0]);
    assign rd_valid_out = (cnt_r != '0);
    assign push = wr_valid_in & wr_ready_out;
    assign pop  = rd_valid_out & rd_ready_in;
    // Read data straight from the storage register at the read pointer
    assign rd_data_out = mem_r[rp_r];

    // ============================================================
    // Storage write; no reset needed on data
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wp_r] <= wr_data_in;
        end
    end

    // ============================================================
    // Pointers and count
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else if (flush_in) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

/* File: verilog/sled_top.sv */
// Serial line error detector: receive checks, buffer, transmit refusal
// Timing summary
// Receive: code and flags change one edge after a character is
// taken; a clean character reaches the read output two edges later.
// Transmit: a granted request leaves as a one-cycle start pulse with
// its data; a refused one leaves nothing but the code and the flag.
// Clear: flags and code fall one edge after the request, except
// where an error lands in that same cycle, which is kept instead.
// Limitation: the carrier and connection pins are seen two cycles
// late, so a character right after a carrier change is judged on
// the old level; partners should raise carrier well before sending.
`timescale 1ns/1ps
`include "sled_cfg.svh"
module sled_top #(
    parameter int DEPTH = `SLED_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    sys_rst_in,
    // Receiver front end, same clock
    input  wire logic                    rx_valid_in,
    input  wire sled_pkg::sled_rx_char_type rx_char_in,
    input  wire logic                    rx_busy_in,
    // Carrier and line pins, asynchronous
    input  wire logic                    carrier_in,
    input  wire logic                    line_conn_in,
    // Configuration
    input  wire logic                    cd_check_en_in,
    // Host receive side
    output logic                         rd_req_out,
    output logic [7:0]                   rd_data_out,
    input  wire logic                    rd_ack_in,
    // Host transmit side
    input  wire logic                    tx_req_in,
    input  wire logic [7:0]              tx_data_in,
    output logic                         tx_start_out,
    output logic [7:0]                   tx_data_out,
    // Error reporting
    input  wire logic                    error_clear_request_in,
    output logic [15:0]                  err_code_out,
    output logic                         serial_error_flag_out,
    output logic                         parity_error_flag_out,
    output logic                         channel_error_flag_out
);
    // ============================================================
    // Declarations
    logic [1:0] cd_sync_r;     // Carrier synchroniser
    logic [1:0] conn_sync_r;   // Line connected synchroniser
    logic       carrier_on;    // Synchronised carrier
    logic       conn_on;       // Synchronised connection
    logic       fifo_ready;    // Buffer has room
    logic       fifo_valid;    // Buffer holds a character
    logic [7:0] fifo_data;     // Head of buffer
    logic       take;          // Character accepted by the checks
    logic       ev_overrun;    // Overrun event
    logic       ev_framing;    // Framing event
    logic       ev_parity;     // Parity event
    logic       ev_full;       // Overflow event
    logic       ev_carrier;    // Carrier event
    logic       ev_tx_refuse;  // Transmit refusal event
    logic       out_busy_r;    // Read output holds a character
    logic       pop;           // Move head to read output
    logic [15:0] code_nxt;     // Next error code
    sled_pkg::sled_flags_type flags_r;  // Latched flags

    // ============================================================
    // Pin synchronisers; first stage feeds only the second
    // Both reset to off, so a line reads as down for two edges
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cd_sync_r   <= 2'h0;
            conn_sync_r <= 2'h0;
        end else begin
            cd_sync_r   <= {cd_sync_r[0], carrier_in};
            conn_sync_r <= {conn_sync_r[0], line_conn_in};
        end
    end
    assign carrier_on = cd_sync_r[1];
    assign conn_on    = conn_sync_r[1];

    // ============================================================
    // Receive event decode
    // Overrun characters are still buffered: the newest data is kept
    // Carrier is only judged when checking is enabled
    assign ev_carrier = rx_valid_in & cd_check_en_in & ~carrier_on;
    assign ev_framing = rx_valid_in & ~rx_char_in.stop_ok;
    assign ev_parity  = rx_valid_in & ~rx_char_in.parity_ok;
    // A new character while the front end is still busy is an overrun
    assign ev_overrun = rx_valid_in & rx_busy_in;
    // Only characters with good stop and parity, and good carrier when checking is on, enter the buffer
    assign take = rx_valid_in & ~ev_carrier & ~ev_framing & ~ev_parity;
    // No room: character is dropped, not written
    assign ev_full = take & ~fifo_ready;
    // Transmit refusal when the line is down
    assign ev_tx_refuse = tx_req_in & ~conn_on;

    // ============================================================
    // Receive buffer
    // Only characters that passed the carrier, stop and parity checks are offered; the flush
    // input stays low since errors never discard buffered data
    sled_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_in       (clk_in),
        .sys_rst_in   (sys_rst_in),
        .wr_valid_in  (take),
        .wr_ready_out (fifo_ready),
        .wr_data_in   (rx_char_in.data),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (pop),
        .rd_data_out  (fifo_data),
        .flush_in     (1'b0)
    );

    // ============================================================
    // Read output stage; host back-pressure stalls the buffer
    // The output register adds one place to the buffer: a flood
    // fills the buffer and this stage before anything is dropped
    assign pop = fifo_valid & (~out_busy_r | rd_ack_in);
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            out_busy_r  <= 1'b0;
            rd_data_out <= 8'h00;
        end else begin
            if (pop) begin
                out_busy_r  <= 1'b1;
                rd_data_out <= fifo_data;
            end else if (rd_ack_in) begin
                out_busy_r  <= 1'b0;
            end
        end
    end
    assign rd_req_out = out_busy_r;

    // ============================================================
    // Transmit gate; nothing goes out without a connection
    // Data loads only on a grant, so a refused request leaves the
    // last data that really went out on the output
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_start_out <= 1'b0;
            tx_data_out  <= 8'h00;
        end else begin
            tx_start_out <= tx_req_in & conn_on;
            if (tx_req_in && conn_on) begin
                tx_data_out <= tx_data_in;
            end
        end
    end

    // ============================================================
    // Error code priority: when several fire at once, report the one
    // the host most needs to act on; the flags still record all
    // Carrier comes first because a dead carrier makes every other
    // check on that character meaningless
    always_comb begin
        code_nxt = err_code_out;
        if (error_clear_request_in) begin
            code_nxt = `SLED_CODE_NONE;
        end
        // Events override the clear so none is lost
        if (ev_tx_refuse) begin
            code_nxt = `SLED_CODE_TX_REFUSE;
        end
        if (ev_full) begin
            code_nxt = `SLED_CODE_BUF_FULL;
        end
        if (ev_parity) begin
            code_nxt = `SLED_CODE_PARITY;
        end
        if (ev_framing) begin
            code_nxt = `SLED_CODE_FRAMING;
        end
        if (ev_overrun) begin
            code_nxt = `SLED_CODE_OVERRUN;
        end
        if (ev_carrier) begin
            code_nxt = `SLED_CODE_CARRIER;
        end
    end

    // ============================================================
    // Code register, held until cleared or replaced
    // Reset is the only other way back to the none code
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            err_code_out <= `SLED_CODE_NONE;
        end else begin
            err_code_out <= code_nxt;
        end
    end

    // ============================================================
    // Sticky flags; set wins over clear
    // A spurious flag costs the host a read; a lost one hides a fault
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            flags_r <= '0;
        end else begin
            flags_r.serial_err  <= (flags_r.serial_err
                                    & ~error_clear_request_in)
                                   | ev_framing | ev_overrun
                                   | ev_full;
            flags_r.parity_err  <= (flags_r.parity_err
                                    & ~error_clear_request_in)
                                   | ev_parity;
            flags_r.channel_err <= (flags_r.channel_err
                                    & ~error_clear_request_in)
                                   | ev_carrier | ev_tx_refuse;
        end
    end
    assign serial_error_flag_out  = flags_r.serial_err;
    assign parity_error_flag_out  = flags_r.parity_err;
    assign channel_error_flag_out = flags_r.channel_err;

    // ============================================================
    // Checks
    // Each property except carrier_off_a looks one edge after the event that it guards
    framing_code_a: assert property (
        @(posedge clk_in) disable iff (sys_rst_in)
        (ev_framing && !ev_overrun && !ev_carrier)
        |=> (err_code_out == `SLED_CODE_FRAMING) && serial_error_flag_out)
        else $error("framing code or flag missing");
    parity_code_a: assert property (
        @(posedge clk_in) disable iff (sys_rst_in)
        (ev_parity && !ev_framing && !ev_overrun && !ev_carrier)
        |=> (err_code_out == `SLED_CODE_PARITY) && parity_error_flag_out)
        else $error("parity code or flag missing");
    full_drop_a: assert property (
        @(posedge clk_in) disable iff (sys_rst_in)
        ev_full |=> serial_error_flag_out
                    && (u_fifo.cnt_r <= $past(u_fifo.cnt_r))
                    && ((err_code_out == `SLED_CODE_BUF_FULL)
                        || $past(ev_overrun)))
        else $error("overflow not flagged or data written");
    carrier_err_a: assert property (
        @(posedge clk_in) disable iff (sys_rst_in)
        (rx_valid_in && cd_check_en_in && !carrier_on)
        |=> (err_code_out == `SLED_CODE_CARRIER) && channel_error_flag_out)
        else $error("carrier error not reported");
    carrier_off_a: assert property (
        @(posedge clk_in) disable iff (sys_rst_in)
        (!cd_check_en_in && rx_valid_in && rx_char_in.stop_ok
         && rx_char_in.parity_ok) |-> take && !ev_carrier)
        else $error("carrier judged while checking off");
    tx_refuse_a: assert property (
        @(posedge clk_in) disable iff (sys_rst_in)
        (tx_req_in && !conn_on) |=> !tx_start_out && channel_error_flag_out)
        else $error("transmit not refused");
    clear_flags_a: assert property (
        @(posedge clk_in) disable iff (sys_rst_in)
        (error_clear_request_in && !rx_valid_in && !tx_req_in)
        |=> !serial_error_flag_out && !parity_error_flag_out
            && !channel_error_flag_out && err_code_out == 16'h0000)
        else $error("clear did not wipe errors");
    overrun_code_a: assert property (
        @(posedge clk_in) disable iff (sys_rst_in)
        (ev_overrun && !ev_carrier)
        |=> (err_code_out == `SLED_CODE_OVERRUN) && serial_error_flag_out)
        else $error("overrun not reported");
    code_hold_a: assert property (
        @(posedge clk_in) disable iff (sys_rst_in)
        (!rx_valid_in && !tx_req_in && !error_clear_request_in)
        |=> $stable(err_code_out))
        else $error("error code changed without cause");

    // A granted request leaves with its data one edge later
    tx_pass_a: assert property (
        @(posedge clk_in) disable iff (sys_rst_in)
        (tx_req_in && conn_on)
        |=> tx_start_out && (tx_data_out == $past(tx_data_in)))
        else $error("granted transmit not passed on");
    // An error in the same cycle as a clear must survive it
    clear_race_a: assert property (
        @(posedge clk_in) disable iff (sys_rst_in)
        (error_clear_request_in && ev_framing) |=> serial_error_flag_out)
        else $error("error lost to a simultaneous clear");
    // Both bad bits raise both flags; the code shows the framing fault
    both_flags_a: assert property (
        @(posedge clk_in) disable iff (sys_rst_in)
        (ev_framing && ev_parity)
        |=> serial_error_flag_out && parity_error_flag_out)
        else $error("combined fault missed a flag");
    // A waiting character stays put until the host takes it
    read_hold_a: assert property (
        @(posedge clk_in) disable iff (sys_rst_in)
        (rd_req_out && !rd_ack_in) |=> rd_req_out && $stable(rd_data_out))
        else $error("waiting character lost");

    // Scenarios the bench is expected to reach
    clean_rx_c: cover property (@(posedge clk_in) take && fifo_ready);
    overrun_c:  cover property (@(posedge clk_in) ev_overrun && take);
    full_c:     cover property (@(posedge clk_in) ev_full);
    refuse_c:   cover property (@(posedge clk_in) ev_tx_refuse);
    clear_c:    cover property (@(posedge clk_in)
                    serial_error_flag_out ##1 error_clear_request_in);
endmodule

/* File: bench/sled_peer.sv */
// Far-side serial station model feeding the receiver front end
`timescale 1ns/1ps
module sled_peer (
    // Clock
    input  wire logic                    clk_in,
    // Receiver front end
    output sled_pkg::sled_rx_char_type   rx_char_out,
    output logic                         rx_valid_out,
    output logic                         rx_busy_out,
    // Modem pin, high means carrier on
    output logic                         carrier_out
);
    // =========================================================
    // Line state
    sled_pkg::sled_rx_char_type last_r;   // Last character put on the line

    // Idle line at time zero, carrier on
    initial begin
        rx_valid_out = 1'b0;
        rx_busy_out  = 1'b0;
        carrier_out  = 1'b1;
        rx_char_out  = '0;
        last_r       = '0;
    end

    // =========================================================
    // Put one character on the line at the next falling edge
    // Only this station talks, so no collisions arise
    // Callers may chain sends for back-to-back characters
    task automatic send(input logic [7:0] d, input logic stop_ok,
                        input logic par_ok, input logic busy);
        @(negedge clk_in);
        last_r       = '{data: d, stop_ok: stop_ok, parity_ok: par_ok};
        rx_char_out  = last_r;
        rx_valid_out = 1'b1;
        rx_busy_out  = busy;
    endtask

    // Release the line; stale bits are inverted so no one trusts them
    task automatic idle(input int gap);
        @(negedge clk_in);
        rx_valid_out = 1'b0;
        rx_busy_out  = 1'b0;
        rx_char_out  = ~last_r;
        repeat (gap) @(negedge clk_in);
    endtask

    // Carrier normally stays on whenever sending
    task automatic set_carrier(input logic on);
        @(negedge clk_in);
        carrier_out = on;
    endtask
endmodule

/* File: bench/sled_tb.sv */
// Self-checking bench for the serial line error detector
`timescale 1ns/1ps
`include "sled_cfg.svh"
module tb;
    // =========================================================
    // Stimulus rows: line condition and expected reaction
    typedef struct packed {
        logic        cd_en;  // Carrier checking on
        logic        car;    // Carrier pin level
        logic        stp;    // Stop bit good
        logic        par;    // Parity good
        logic        busy;   // Front end still busy
        logic [15:0] code;   // Expected code
        logic [2:0]  flags;  // Expected serial, parity, channel
        logic        buf_ok; // Character should reach the host
    } sled_row_type;
    sled_row_type rows [7] = '{
        '{1,1,1,1,0,`SLED_CODE_NONE,   3'b000,1},   // Clean
        '{1,1,0,1,0,`SLED_CODE_FRAMING,3'b100,0},
        '{1,1,1,0,0,`SLED_CODE_PARITY, 3'b010,0},
        '{1,0,1,1,0,`SLED_CODE_CARRIER,3'b001,0},
        '{0,0,1,1,0,`SLED_CODE_NONE,   3'b000,1},
        '{1,1,1,1,1,`SLED_CODE_OVERRUN,3'b100,1},
        '{1,1,0,0,0,`SLED_CODE_FRAMING,3'b110,0}};  // Both bad

    // =========================================================
    // Signals
    logic clk, rst, cd_en, conn, ack, tx_req, clr;
    logic [7:0]  tx_d;
    logic        rd_req, tx_start, f_ser, f_par, f_chn;
    logic [7:0]  rd_d, tx_q;
    logic [15:0] code;
    logic        rx_v, rx_b, car;
    sled_pkg::sled_rx_char_type rx_c;
    int err_total = 0;
    int n_tests   = 0;
    int cyc       = 0;

    // =========================================================
    // Clock and instances
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    sled_peer peer_u (.clk_in(clk), .rx_char_out(rx_c), .rx_valid_out(rx_v),
                      .rx_busy_out(rx_b), .carrier_out(car));
    sled_top #(.DEPTH(`SLED_FIFO_DEPTH)) dut_u (
        .clk_in(clk), .sys_rst_in(rst), .rx_valid_in(rx_v),
        .rx_char_in(rx_c), .rx_busy_in(rx_b), .carrier_in(car),
        .line_conn_in(conn), .cd_check_en_in(cd_en), .rd_req_out(rd_req),
        .rd_data_out(rd_d), .rd_ack_in(ack), .tx_req_in(tx_req),
        .tx_data_in(tx_d), .tx_start_out(tx_start), .tx_data_out(tx_q),
        .error_clear_request_in(clr), .err_code_out(code),
        .serial_error_flag_out(f_ser), .parity_error_flag_out(f_par),
        .channel_error_flag_out(f_chn));

    // =========================================================
    // Compare tasks, one per kind of result
    task automatic bad(input string what);
        err_total++;
        $display("Error at %0t: %s mismatch", $time, what);
    endtask
    task automatic chk_code(input logic [15:0] exp);
        n_tests++;
        if (code !== exp) bad("error code");
    endtask
    task automatic chk_flags(input logic [2:0] exp);
        n_tests++;
        if ({f_ser, f_par, f_chn} !== exp) bad("flags");
    endtask
    task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) bad("data");
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) bad("status bit");
    endtask

    // Closing report; the single place where the run ends
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard: the full run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad("timeout");
            print_verdict();
        end
    end

    // =========================================================
    // Host helpers
    // Wait for the read request under a bound, check, then acknowledge
    task automatic read_chk(input logic [7:0] exp);
        for (int k = 0; k < 20 && rd_req !== 1'b1; k++) @(negedge clk);
        chk_bit(rd_req, 1'b1);
        chk_data(rd_d, exp);
        ack <= 1'b1;
        @(negedge clk);
        ack <= 1'b0;
        @(negedge clk);
    endtask
    // One-cycle clear pulse; the result is visible at the next low phase
    task automatic clear_chk;
        clr <= 1'b1;
        @(negedge clk);
        clr <= 1'b0;
        chk_code(`SLED_CODE_NONE);
        chk_flags(3'b000);
    endtask
    task automatic tx_pulse(input logic [7:0] d);
        tx_req <= 1'b1;
        tx_d   <= d;
        @(negedge clk);
        tx_req <= 1'b0;
    endtask

    // =========================================================
    // Main sequence
    initial begin
        rst = 1'b1; cd_en = 1'b1; conn = 1'b1; ack = 1'b0;
        tx_req = 1'b0; tx_d = 8'h00; clr = 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk_code(`SLED_CODE_NONE);
        chk_flags(3'b000);
        rst <= 1'b0;
        repeat (4) @(negedge clk);
        // Table cases: one character per row, then read if it reached the host, and clear
        foreach (rows[i]) begin
            cd_en <= rows[i].cd_en;
            peer_u.set_carrier(rows[i].car);
            repeat (4) @(negedge clk);
            peer_u.send(8'hA0 + 8'(i), rows[i].stp, rows[i].par, rows[i].busy);
            peer_u.idle(0);
            @(negedge clk);
            chk_code(rows[i].code);
            chk_flags(rows[i].flags);
            @(negedge clk);
            chk_bit(rd_req, rows[i].buf_ok);
            if (rows[i].buf_ok) read_chk(8'hA0 + 8'(i));
            clear_chk();
        end
        // Transmit while connected goes onward for exactly one cycle
        cd_en <= 1'b1;
        peer_u.set_carrier(1'b1);
        tx_pulse(8'h5A);
        chk_bit(tx_start, 1'b1);
        chk_data(tx_q, 8'h5A);
        @(negedge clk);
        chk_bit(tx_start, 1'b0);
        // Transmit with the line down is refused
        conn <= 1'b0;
        repeat (4) @(negedge clk);
        tx_pulse(8'hC3);
        chk_bit(tx_start, 1'b0);
        chk_code(`SLED_CODE_TX_REFUSE);
        chk_flags(3'b001);
        clear_chk();
        // Flood without flow control: nine fit, the tenth is dropped
        for (int j = 0; j < 10; j++) begin
            peer_u.send(8'(j), 1'b1, 1'b1, 1'b0);
        end
        peer_u.idle(0);
        @(negedge clk);
        chk_code(`SLED_CODE_BUF_FULL);
        chk_flags(3'b100);
        for (int j = 0; j < 9; j++) read_chk(8'(j));
        repeat (4) @(negedge clk);
        chk_bit(rd_req, 1'b0);
        chk_code(`SLED_CODE_BUF_FULL);
        // Error and clear in one cycle: the error survives
        peer_u.send(8'h3C, 1'b0, 1'b1, 1'b0);
        clr <= 1'b1;
        peer_u.idle(0);
        clr <= 1'b0;
        @(negedge clk);
        chk_code(`SLED_CODE_FRAMING);
        chk_flags(3'b100);
        // Reset in mid-run wipes the held code
        rst <= 1'b1;
        @(negedge clk);
        rst <= 1'b0;
        chk_code(`SLED_CODE_NONE);
        chk_flags(3'b000);
        print_verdict();
    end
endmodule
